// File: rtl/imsm_master.sv
// bus master for the memory's special sequences: high speed, sleep, id, recovery
//
// Summary of operation
// [R1] high-speed entry: start, then code 00001xxx
// [R2] slave never acknowledges the high-speed code
// [R3] after that nack, bus runs high speed
// [R4] stop condition ends high-speed operation
// [R5] high speed: repeated start, then ordinary framing
// [R6] sleep entry starts with start and F8h
// [R7] device address word follows, read/write ignored
// [R8] then repeated start and byte 86h
// [R9] slave sleeps after acknowledging 86h
// [R10] wake: start plus address word, rw ignored
// [R11] recovery starts at ninth rising scl edge
// [R12] wait recovery, then commands need fresh start
// [R13] slave holds fixed three-byte identification
// [R14] id read: start, F8h, then address word
// [R15] repeated start, F9h, then id bytes
// [R16] master nacks third id byte
// [R17] master only releases sda, never drives high
// [R18] after failure: reset sequence or retry
// [R19] reset: up to nine clocks, start, stop
// [R20] address word: type 1010, straps, rw bit
// [R21] mismatched address: slave does not respond
`timescale 1ns/1ps
module imsm_master import imsm_pkg::*; #(
   parameter int REC_CYC = REC_CYC_DEF
) (
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_n_in,
   // operation request
   input wire logic op_valid_in,
   input wire imsm_op_type op_in,
   input wire logic [7:0] op_data_in,
   input wire logic op_ack_in,
   output logic op_ready_out,
   output logic op_done_out,
   output logic op_error_out,
   // results and status
   output logic [7:0] rdata_out,
   output logic slave_ack_out,
   output logic [23:0] dev_id_out,
   output logic hs_active_out,
   output logic sleeping_out,
   // address straps of the target
   input wire logic addr_strap_bit2_in,
   input wire logic addr_strap_bit1_in,
   input wire logic addr_strap_bit0_in,
   // bus pins
   input wire logic scl_pin_in,
   output logic scl_out,
   output logic scl_oe_out,
   input wire logic sda_pin_in,
   output logic sda_out,
   output logic sda_oe_out
);

   if (REC_CYC < 1) begin : g_bad_rec
      $error("recovery count must be at least one");
   end

   localparam int REC_W = $clog2(REC_CYC + 1);
   localparam logic [REC_W-1:0] REC_LOAD = REC_W'(REC_CYC - 1);
   localparam logic [3:0] FLUSH_LAST = 4'(RESET_MAX_CLOCKS - 1);
   localparam logic [3:0] ID_LAST_IDX = 4'(ID_FIRST_IDX + ID_BYTES - 1);

   typedef enum logic [2:0] {
      ST_IDLE, ST_FETCH, ST_CMD, ST_BYTE, ST_FLUSH, ST_RECOVER, ST_ABORT
   } imsm_state_type;

   typedef struct packed {
      imsm_state_type st;
      imsm_op_type op;
      logic [7:0] wdata;
      logic rack;
      logic [3:0] idx;
      imsm_item_type item;
      logic [3:0] bitn;
      logic [7:0] sh;
      logic [3:0] flush_n;
      logic [REC_W-1:0] rec_cnt;
      logic err;
      logic done;
      logic [7:0] rdata;
      logic sack;
      logic [23:0] id;
      logic hs;
      logic asleep;
      logic cv;
      imsm_cmd_type cmd;
      logic bitv;
      logic [2:0] strap_s1;
      logic [2:0] strap_s2;
   } imsm_master_type;

   imsm_master_type q, d;
   imsm_item_type it_c;
   logic [7:0] dev_word;
   logic eng_done;
   logic eng_rbit;
   logic is_read_c;
   logic expect_fail_c;

   ////////////////////////////////////////////////////////////////////////////
   // sequence tables
   function automatic imsm_item_type mk(imsm_kind_type k, logic [7:0] v);
      imsm_item_type r;
      r.kind = k;
      r.data = v;
      return r;
   endfunction : mk

   function automatic imsm_item_type seq_item(imsm_op_type op, logic [3:0] idx,
                                              logic [7:0] wd, logic ra, logic [7:0] dev);
      imsm_item_type r;
      r = mk(IT_END, 8'h00);
      case (op)
         OP_START: if (idx == 4'h0) r = mk(IT_START, 8'h00);
         OP_STOP: if (idx == 4'h0) r = mk(IT_STOP, 8'h00);
         OP_WRITE: if (idx == 4'h0) r = mk(IT_WANY, wd);
         OP_READ: if (idx == 4'h0) r = mk(ra ? IT_RACK : IT_RNACK, 8'h00);
         OP_HS_ENTER: begin
            case (idx)
               4'h0: r = mk(IT_START, 8'h00); // R1
               4'h1: r = mk(IT_WNACK, {HS_CODE_BASE[7:3], wd[2:0]}); // R1
               default: r = mk(IT_END, 8'h00);
            endcase
         end
         OP_SLEEP: begin
            case (idx)
               4'h0: r = mk(IT_START, 8'h00); // R6
               4'h1: r = mk(IT_WACK, RSVD_ID_WR); // R6
               4'h2: r = mk(IT_WACK, dev); // R7
               4'h3: r = mk(IT_START, 8'h00); // R8
               4'h4: r = mk(IT_WACK, SLEEP_CMD); // R8
               4'h5: r = mk(IT_STOP, 8'h00);
               default: r = mk(IT_END, 8'h00);
            endcase
         end
         OP_WAKE: begin
            case (idx)
               4'h0: r = mk(IT_START, 8'h00); // R10
               4'h1: r = mk(IT_WANY, dev); // R10
               4'h2: r = mk(IT_WAIT, 8'h00); // R11
               4'h3: r = mk(IT_STOP, 8'h00);
               default: r = mk(IT_END, 8'h00);
            endcase
         end
         OP_READ_ID: begin
            if (idx == 4'h0 || idx == 4'h3) begin
               r = mk(IT_START, 8'h00); // R14
            end else if (idx == 4'h1) begin
               r = mk(IT_WACK, RSVD_ID_WR); // R14
            end else if (idx == 4'h2) begin
               r = mk(IT_WACK, dev); // R14
            end else if (idx == 4'h4) begin
               r = mk(IT_WACK, RSVD_ID_RD); // R15
            end else if (idx < ID_LAST_IDX) begin
               r = mk(IT_RACK, 8'h00); // R15
            end else if (idx == ID_LAST_IDX) begin
               r = mk(IT_RNACK, 8'h00); // R16
            end else if (idx == ID_LAST_IDX + 4'h1) begin
               r = mk(IT_STOP, 8'h00);
            end
         end
         OP_BUS_RESET: begin
            case (idx)
               4'h0: r = mk(IT_FLUSH, 8'h00); // R19
               4'h1: r = mk(IT_START, 8'h00); // R19
               4'h2: r = mk(IT_STOP, 8'h00); // R19
               default: r = mk(IT_END, 8'h00);
            endcase
         end
         default: r = mk(IT_END, 8'h00);
      endcase
      return r;
   endfunction : seq_item

   // bit to put out at position n of a byte item; position 8 is the ack slot
   function automatic logic byte_bit(imsm_kind_type k, logic [7:0] s, logic [3:0] n);
      logic b;
      b = 1'b1;
      if (n == 4'h8) begin
         b = (k == IT_RACK) ? 1'b0 : 1'b1;
      end else if (k == IT_WACK || k == IT_WNACK || k == IT_WANY) begin
         b = s[7];
      end
      return b;
   endfunction : byte_bit

   ////////////////////////////////////////////////////////////////////////////
   // next state
   assign dev_word = {DEV_TYPE_CODE, q.strap_s2, 1'b0}; // R20
   assign it_c = seq_item(q.op, q.idx, q.wdata, q.rack, dev_word);
   assign is_read_c = (q.item.kind == IT_RACK) || (q.item.kind == IT_RNACK);
   // an address nack is how a mismatched or absent slave shows
   assign expect_fail_c = ((q.item.kind == IT_WACK) && eng_rbit) || // R21
                          ((q.item.kind == IT_WNACK) && !eng_rbit); // R2

   always_comb begin
      d = q;
      d.cv = 1'b0;
      d.done = 1'b0;
      d.strap_s1 = {addr_strap_bit2_in, addr_strap_bit1_in, addr_strap_bit0_in};
      d.strap_s2 = q.strap_s1;
      case (q.st)
         ST_IDLE: begin
            if (op_valid_in) begin
               d.op = op_in;
               d.wdata = op_data_in;
               d.rack = op_ack_in;
               d.idx = 4'h0;
               d.err = 1'b0;
               if (q.asleep && op_in != OP_WAKE && op_in != OP_BUS_RESET) begin
                  d.err = 1'b1; // R10
                  d.done = 1'b1;
               end else begin
                  d.st = ST_FETCH;
               end
            end
         end
         ST_FETCH: begin
            d.item = it_c;
            case (it_c.kind)
               IT_START: begin
                  d.cv = 1'b1;
                  d.cmd = CMD_START;
                  d.st = ST_CMD;
               end
               IT_STOP: begin
                  d.cv = 1'b1;
                  d.cmd = CMD_STOP;
                  d.st = ST_CMD;
               end
               IT_WAIT: begin
                  d.rec_cnt = REC_LOAD; // R11
                  d.st = ST_RECOVER;
               end
               IT_FLUSH: begin
                  d.flush_n = 4'h0;
                  d.cv = 1'b1;
                  d.cmd = CMD_BIT;
                  d.bitv = 1'b1; // R17
                  d.st = ST_FLUSH;
               end
               IT_END: begin
                  d.done = 1'b1;
                  d.st = ST_IDLE;
                  if (q.op == OP_HS_ENTER && !q.err) begin
                     d.hs = 1'b1; // R3
                  end
                  if (q.op == OP_SLEEP && !q.err) begin
                     d.asleep = 1'b1; // R9
                  end
                  if (q.op == OP_WAKE || q.op == OP_BUS_RESET) begin
                     d.asleep = 1'b0; // R12
                  end
               end
               default: begin
                  d.sh = it_c.data;
                  d.bitn = 4'h0;
                  d.cv = 1'b1;
                  d.cmd = CMD_BIT;
                  d.bitv = byte_bit(it_c.kind, it_c.data, 4'h0);
                  d.st = ST_BYTE;
               end
            endcase
         end
         ST_CMD: begin
            if (eng_done) begin
               if (q.item.kind == IT_STOP) begin
                  d.hs = 1'b0; // R4
               end
               d.idx = q.idx + 4'h1;
               d.st = ST_FETCH;
            end
         end
         ST_BYTE: begin
            if (eng_done) begin
               if (q.bitn != 4'h8) begin
                  d.sh = {q.sh[6:0], eng_rbit};
                  d.bitn = q.bitn + 4'h1;
                  d.cv = 1'b1;
                  d.cmd = CMD_BIT;
                  d.bitv = byte_bit(q.item.kind, d.sh, d.bitn);
               end else begin
                  if (is_read_c) begin
                     d.rdata = q.sh;
                     if (q.op == OP_READ_ID) begin
                        d.id = {q.id[15:0], q.sh}; // R13
                     end
                  end else begin
                     d.sack = !eng_rbit;
                  end
                  if (expect_fail_c) begin
                     d.err = 1'b1; // R18
                     d.cv = 1'b1;
                     d.cmd = CMD_STOP;
                     d.st = ST_ABORT;
                  end else begin
                     d.idx = q.idx + 4'h1;
                     d.st = ST_FETCH;
                  end
               end
            end
         end
         ST_FLUSH: begin
            if (eng_done) begin
               if (eng_rbit || q.flush_n == FLUSH_LAST) begin
                  d.idx = q.idx + 4'h1; // R19
                  d.st = ST_FETCH;
               end else begin
                  d.flush_n = q.flush_n + 4'h1;
                  d.cv = 1'b1;
                  d.cmd = CMD_BIT;
                  d.bitv = 1'b1;
               end
            end
         end
         ST_RECOVER: begin
            if (q.rec_cnt == '0) begin
               d.idx = q.idx + 4'h1; // R12
               d.st = ST_FETCH;
            end else begin
               d.rec_cnt = q.rec_cnt - REC_W'(1);
            end
         end
         ST_ABORT: begin
            if (eng_done) begin
               d.hs = 1'b0; // R4
               d.done = 1'b1;
               d.st = ST_IDLE;
            end
         end
         default: d.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bit engine
   imsm_bit_engine #(
      .QTR_STD(QTR_STD_CYC),
      .QTR_HS(QTR_HS_CYC)
   ) u_engine (
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .cmd_valid_in(q.cv),
      .cmd_in(q.cmd),
      .bit_in(q.bitv),
      .hs_in(q.hs), // R5
      .ready_out(),
      .done_out(eng_done),
      .rbit_out(eng_rbit),
      .scl_pin_in(scl_pin_in),
      .scl_out(scl_out),
      .scl_oe_out(scl_oe_out),
      .sda_pin_in(sda_pin_in),
      .sda_out(sda_out),
      .sda_oe_out(sda_oe_out)
   );

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign op_ready_out = (q.st == ST_IDLE);
   assign op_done_out = q.done;
   assign op_error_out = q.err;
   assign rdata_out = q.rdata;
   assign slave_ack_out = q.sack;
   assign dev_id_out = q.id;
   assign hs_active_out = q.hs;
   assign sleeping_out = q.asleep;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);

   property p_hs_code;
      (q.st == ST_BYTE && q.item.kind == IT_WNACK) |-> (q.item.data[7:3] == 5'h01);
   endproperty
   a_hs_code: assert property (p_hs_code) else $error("bad high-speed code"); // R1

   property p_hs_rise;
      $rose(hs_active_out) |-> (op_done_out && !op_error_out);
   endproperty
   a_hs_rise: assert property (p_hs_rise) else $error("high speed set without clean entry"); // R3

   sequence s_stop_end;
      q.st == ST_CMD && q.item.kind == IT_STOP && eng_done;
   endsequence
   property p_stop_hs;
      s_stop_end |=> !hs_active_out;
   endproperty
   a_stop_hs: assert property (p_stop_hs) else $error("high speed kept after stop"); // R4

   property p_sleep_code;
      (q.st == ST_BYTE && q.op == OP_SLEEP && q.idx == 4'h4) |-> (q.item.data == SLEEP_CMD);
   endproperty
   a_sleep_code: assert property (p_sleep_code) else $error("wrong sleep command byte"); // R8

   sequence s_id_last_bit;
      q.st == ST_BYTE && q.item.kind == IT_RNACK && q.bitn == 4'h7 && eng_done;
   endsequence
   property p_id_nack;
      s_id_last_bit |=> (q.cv && q.bitv && q.bitn == 4'h8);
   endproperty
   a_id_nack: assert property (p_id_nack) else $error("last read byte not nacked"); // R16

   property p_flush_bound;
      (q.st == ST_FLUSH) |-> (q.flush_n <= FLUSH_LAST);
   endproperty
   a_flush_bound: assert property (p_flush_bound) else $error("too many reset clocks"); // R19

   property p_abort_stop;
      $rose(q.st == ST_ABORT) |-> (q.cv && q.cmd == CMD_STOP && op_error_out);
   endproperty
   a_abort_stop: assert property (p_abort_stop) else $error("failure not closed by stop"); // R18

   property p_wake_done;
      $fell(sleeping_out) |-> op_done_out;
   endproperty
   a_wake_done: assert property (p_wake_done) else $error("sleep left before wake finished"); // R12

   property p_asleep_refuse;
      (q.st == ST_IDLE && op_valid_in && q.asleep && op_in == OP_READ_ID)
         |=> (op_done_out && op_error_out && op_ready_out);
   endproperty
   a_asleep_refuse: assert property (p_asleep_refuse) else $error("op run while asleep"); // R10

endmodule : imsm_master

// File: rtl/imsm_pkg.sv
// shared constants and types of the special-mode two-wire bus master
package imsm_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // clock and bus rates
   localparam int CLK_FREQ_KHZ = 40000;
   localparam int CLK_PERIOD_NS = 25;
   // normal rate is fast mode plus, high-speed rate is 3.4 MHz
   localparam int SCL_STD_FREQ_KHZ = 1000;
   localparam int SCL_HS_FREQ_KHZ = 3400;
   // quarter bit periods, rounded up so the bus never runs too fast
   localparam int QTR_STD_CYC = (CLK_FREQ_KHZ + 4 * SCL_STD_FREQ_KHZ - 1) / (4 * SCL_STD_FREQ_KHZ);
   localparam int QTR_HS_CYC = (CLK_FREQ_KHZ + 4 * SCL_HS_FREQ_KHZ - 1) / (4 * SCL_HS_FREQ_KHZ);
   // regulator recovery wait after wake-up, arbitrary default
   localparam int REC_TIME_US = 400;
   localparam int REC_CYC_DEF = (REC_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   ////////////////////////////////////////////////////////////////////////////
   // bus codes
   localparam logic [7:0] HS_CODE_BASE = 8'h08;
   localparam logic [7:0] RSVD_ID_WR = 8'hF8;
   localparam logic [7:0] RSVD_ID_RD = 8'hF9;
   localparam logic [7:0] SLEEP_CMD = 8'h86;
   localparam logic [3:0] DEV_TYPE_CODE = 4'hA;
   localparam int ID_BYTES = 3;
   localparam int ID_FIRST_IDX = 5;
   localparam int RESET_MAX_CLOCKS = 9;

   ////////////////////////////////////////////////////////////////////////////
   // operations, bit-engine commands and sequence items
   typedef enum logic [3:0] {
      OP_START, OP_STOP, OP_WRITE, OP_READ, OP_HS_ENTER,
      OP_SLEEP, OP_WAKE, OP_READ_ID, OP_BUS_RESET
   } imsm_op_type;

   typedef enum logic [1:0] {CMD_START, CMD_STOP, CMD_BIT} imsm_cmd_type;

   typedef enum logic [3:0] {
      IT_START, IT_STOP, IT_WACK, IT_WNACK, IT_WANY,
      IT_RACK, IT_RNACK, IT_WAIT, IT_FLUSH, IT_END
   } imsm_kind_type;

   typedef struct packed {
      imsm_kind_type kind;
      logic [7:0] data;
   } imsm_item_type;

endpackage : imsm_pkg

// File: rtl/imsm_bit_engine.sv
// bit-level engine: start, stop and single bits on the open-drain pins
`timescale 1ns/1ps
module imsm_bit_engine import imsm_pkg::*; #(
   parameter int QTR_STD = QTR_STD_CYC,
   parameter int QTR_HS = QTR_HS_CYC
) (
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_n_in,
   // command side
   input wire logic cmd_valid_in,
   input wire imsm_cmd_type cmd_in,
   input wire logic bit_in,
   input wire logic hs_in,
   output logic ready_out,
   output logic done_out,
   output logic rbit_out,
   // bus pins
   input wire logic scl_pin_in,
   output logic scl_out,
   output logic scl_oe_out,
   input wire logic sda_pin_in,
   output logic sda_out,
   output logic sda_oe_out
);

   if (QTR_STD < 3 || QTR_STD > 16 || QTR_HS < 3 || QTR_HS > 16) begin : g_bad_qtr
      $error("quarter period counts must lie in 3..16");
   end

   localparam logic [3:0] QS_LAST = 4'(QTR_STD - 1);
   localparam logic [3:0] QH_LAST = 4'(QTR_HS - 1);

   typedef struct packed {
      logic busy;
      imsm_cmd_type cmd;
      logic bitv;
      logic hs;
      logic [1:0] qtr;
      logic [3:0] cnt;
      logic scl_oe;
      logic sda_oe;
      logic rbit;
      logic done;
      logic sda_s1;
      logic sda_s2;
      logic scl_s1;
      logic scl_s2;
   } imsm_eng_type;

   imsm_eng_type q, d;
   logic stall_c;
   logic [3:0] last_c;

   // {scl_oe, sda_oe} for each quarter of a command
   function automatic logic [1:0] pin_drive(imsm_cmd_type c, logic b, logic [1:0] qt);
      logic [1:0] r;
      r = 2'h0;
      case (c)
         CMD_START: r = (qt == 2'h3) ? 2'h3 : ((qt == 2'h2) ? 2'h1 : 2'h0);
         CMD_STOP: r = (qt == 2'h0) ? 2'h3 : ((qt == 2'h3) ? 2'h0 : 2'h1);
         default: r = {(qt == 2'h0) || (qt == 2'h3), ~b};
      endcase
      return r;
   endfunction : pin_drive

   ////////////////////////////////////////////////////////////////////////////
   // next state
   assign last_c = q.hs ? QH_LAST : QS_LAST;
   // a slave holding scl low stretches the high phase
   assign stall_c = q.busy && !q.scl_oe && !q.scl_s2 && (q.qtr == 2'h2);

   always_comb begin
      d = q;
      d.done = 1'b0;
      d.sda_s1 = sda_pin_in;
      d.sda_s2 = q.sda_s1;
      d.scl_s1 = scl_pin_in;
      d.scl_s2 = q.scl_s1;
      if (!q.busy) begin
         if (cmd_valid_in) begin
            d.busy = 1'b1;
            d.cmd = cmd_in;
            d.bitv = bit_in;
            d.hs = hs_in;
            d.qtr = 2'h0;
            d.cnt = 4'h0;
            {d.scl_oe, d.sda_oe} = pin_drive(cmd_in, bit_in, 2'h0);
         end
      end else if (!stall_c) begin
         if (q.cnt == last_c) begin
            d.cnt = 4'h0;
            if (q.qtr == 2'h2) begin
               d.rbit = q.sda_s2;
            end
            if (q.qtr == 2'h3) begin
               d.busy = 1'b0;
               d.done = 1'b1;
            end else begin
               d.qtr = q.qtr + 2'h1;
               {d.scl_oe, d.sda_oe} = pin_drive(q.cmd, q.bitv, d.qtr);
            end
         end else begin
            d.cnt = q.cnt + 4'h1;
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs: pins only ever pull low
   assign ready_out = !q.busy;
   assign done_out = q.done;
   assign rbit_out = q.rbit;
   assign scl_out = 1'b0;
   assign scl_oe_out = q.scl_oe;
   assign sda_out = 1'b0; // R17
   assign sda_oe_out = q.sda_oe;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);

   property p_read_released;
      (q.busy && q.cmd == CMD_BIT && q.bitv) |-> !sda_oe_out;
   endproperty
   a_read_released: assert property (p_read_released) else $error("sda driven on a released bit"); // R17

   sequence s_start_mid;
      q.busy && q.cmd == CMD_START && q.qtr == 2'h2;
   endsequence
   property p_start_shape;
      s_start_mid |-> (!scl_oe_out && sda_oe_out);
   endproperty
   a_start_shape: assert property (p_start_shape) else $error("start without sda fall under scl high"); // R1

   property p_done_pulse;
      done_out |=> (!done_out && ready_out);
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done not a single pulse"); // R19

endmodule : imsm_bit_engine

// File: testbench/imsm_slave_model.sv
// behavioural two-wire memory target for the special sequences
`timescale 1ns/1ps
module imsm_slave_model import imsm_pkg::*; #(
   parameter logic [23:0] ID = 24'h3C5A96
) (
   // bus wires and straps
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic [2:0] strap_in,
   // data pull-down
   output logic sda_oe_out
);
   logic [7:0] sr = 8'h00;
   logic [3:0] n = 4'h0;
   logic [2:0] st = 3'h0;
   logic [1:0] ix = 2'h0;
   logic rd = 1'b0;
   logic mack = 1'b0;
   logic slp = 1'b0;
   initial sda_oe_out = 1'b0;
   ////////////////////////////////////////////////////////////////////////////
   always @(negedge sda_in) if (scl_in) begin
      n = 4'h0;
      rd = 1'b0;
   end
   always @(posedge sda_in) if (scl_in) begin
      st = 3'h0;
      rd = 1'b0;
   end
   always @(posedge scl_in) begin
      if (n == 8) slp = 1'b0;
      if (n < 8) sr = {sr[6:0], sda_in};
      else mack = !sda_in;
      n = n + 4'h1;
   end
   always @(negedge scl_in) begin
      sda_oe_out = 1'b0;
      if (n == 9) begin
         n = 4'h0;
         if (rd) begin
            rd = mack;
            ix = (ix == 2) ? 2'h0 : ix + 2'h1;
         end
         if (st == 3) slp = 1'b1;
         if (st == 4) begin
            rd = 1'b1;
            ix = 2'h0;
            st = 3'h5;
         end
      end else if (n == 8 && !rd && !slp) begin
         if (sr == RSVD_ID_WR) st = 3'h1;
         else if (st == 1 && sr[7:1] == {DEV_TYPE_CODE, strap_in}) st = 3'h2;
         else if (st == 2 && sr == SLEEP_CMD) st = 3'h3;
         else if (st == 2 && sr == RSVD_ID_RD) st = 3'h4;
         else st = 3'h7;
         sda_oe_out = (st != 7);
      end
      if (rd && n < 8) sda_oe_out = !ID[23 - 8 * ix - n];
   end
endmodule : imsm_slave_model

// File: testbench/imsm_master_bench.sv
// self-checking bench of the special-mode bus master
`timescale 1ns/1ps
module imsm_master_bench import imsm_pkg::*;;
   localparam int REC = 20;
   localparam logic [23:0] ID = 24'h3C5A96; // arbitrary value
   logic clock_in = 0, rst_n_in = 0, op_valid_in = 0, op_ack_in = 0;
   imsm_op_type op_in = OP_START;
   logic [7:0] op_data_in = 8'h00, rdata_out;
   logic [2:0] strap = 3'h5;
   logic op_ready_out, op_done_out, op_error_out, slave_ack_out, hs_active_out;
   logic sleeping_out, scl_out, scl_oe_out, sda_out, sda_oe_out, s_oe;
   logic [23:0] dev_id_out;
   wire scl_w = !scl_oe_out;
   wire #1 sda_w = !(sda_oe_out | s_oe);
   int mismatches = 0, samples_checked = 0, cyc;
   initial forever #12.5 clock_in = ~clock_in;
   imsm_master #(.REC_CYC(REC)) imsm_master_i (.clock_in, .rst_n_in, .op_valid_in, .op_in,
      .op_data_in, .op_ack_in, .op_ready_out, .op_done_out, .op_error_out, .rdata_out,
      .slave_ack_out, .dev_id_out, .hs_active_out, .sleeping_out,
      .addr_strap_bit2_in(strap[2]), .addr_strap_bit1_in(strap[1]),
      .addr_strap_bit0_in(strap[0]), .scl_pin_in(scl_w), .scl_out, .scl_oe_out,
      .sda_pin_in(sda_w), .sda_out, .sda_oe_out);
   imsm_slave_model #(.ID(ID)) imsm_slave_model_i (.scl_in(scl_w), .sda_in(sda_w),
      .strap_in(3'h5), .sda_oe_out(s_oe));
   ////////////////////////////////////////////////////////////////////////////
   task automatic summarize;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : summarize
   task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic op(input imsm_op_type o, input logic [7:0] d, input logic a);
      @(posedge clock_in);
      #2;
      op_in = o;
      op_data_in = d;
      op_ack_in = a;
      op_valid_in = 1'b1;
      @(posedge clock_in);
      #2;
      op_valid_in = 1'b0;
      for (cyc = 0; cyc < 20000 && op_done_out !== 1'b1; cyc++) begin
         @(posedge clock_in);
         #2;
      end
      if (cyc == 20000) begin
         mismatches++;
         summarize;
      end
      chk("ready", 24'h1, {23'h0, op_ready_out});
   endtask : op
   always @(negedge clock_in) chk("pins_out", 24'h0, {22'h0, scl_out, sda_out});
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_id;
      op(OP_READ_ID, 8'h00, 1'b0);
      chk("id", ID, dev_id_out);
      chk("id_err", 24'h0, {23'h0, op_error_out});
      $display("test id done");
   endtask : t_id
   task automatic t_wrap;
      op(OP_START, 8'h00, 1'b0);
      op(OP_WRITE, RSVD_ID_WR, 1'b0);
      chk("sack_f8", 24'h1, {23'h0, slave_ack_out});
      op(OP_WRITE, {DEV_TYPE_CODE, 3'h5, 1'b1}, 1'b0);
      chk("sack_adr", 24'h1, {23'h0, slave_ack_out});
      op(OP_START, 8'h00, 1'b0);
      op(OP_WRITE, RSVD_ID_RD, 1'b0);
      for (int k = 0; k < 4; k++) begin
         op(OP_READ, 8'h00, k < 3);
         chk("byte", {16'h0, ID[23 - 8 * (k % 3) -: 8]}, {16'h0, rdata_out});
      end
      op(OP_STOP, 8'h00, 1'b0);
      $display("test wrap done");
   endtask : t_wrap
   task automatic t_hs;
      op(OP_HS_ENTER, 8'h07, 1'b0);
      chk("hs", 24'h1, {23'h0, hs_active_out});
      op(OP_READ_ID, 8'h00, 1'b0);
      chk("hs_id", ID, dev_id_out);
      chk("hs_fast", 24'h1, {23'h0, cyc < 57 * 4 * QTR_STD_CYC});
      chk("hs_off", 24'h0, {23'h0, hs_active_out});
      $display("test hs done");
   endtask : t_hs
   task automatic t_sleep;
      op(OP_SLEEP, 8'h00, 1'b0);
      chk("asleep", 24'h1, {23'h0, sleeping_out & imsm_slave_model_i.slp});
      op(OP_READ_ID, 8'h00, 1'b0);
      chk("refused", 24'h1, {23'h0, op_error_out});
      op(OP_WAKE, 8'h00, 1'b0);
      chk("woken", 24'h0, {23'h0, sleeping_out | imsm_slave_model_i.slp});
      chk("rec_wait", 24'h1, {23'h0, cyc > REC + 11 * 4 * QTR_STD_CYC});
      op(OP_READ_ID, 8'h00, 1'b0);
      chk("id_after", ID, dev_id_out);
      $display("test sleep done");
   endtask : t_sleep
   task automatic t_misc;
      strap = 3'h2;
      op(OP_READ_ID, 8'h00, 1'b0);
      chk("mismatch", 24'h1, {23'h0, op_error_out});
      strap = 3'h5;
      op(OP_HS_ENTER, 8'h08, 1'b0);
      op(OP_BUS_RESET, 8'h00, 1'b0);
      chk("rst_err", 24'h0, {23'h0, op_error_out});
      chk("rst_hs", 24'h0, {23'h0, hs_active_out});
      $display("test misc done");
   endtask : t_misc
   initial begin
      repeat (10) @(posedge clock_in);
      #2;
      rst_n_in = 1'b1;
      t_id;
      t_wrap;
      t_hs;
      t_sleep;
      t_misc;
      summarize;
   end
endmodule : imsm_master_bench
